// ==== fps_pkg.sv ====
// constants and types of the sector builder
package fps_pkg;
   localparam int SECTOR_BYTES = 512;
   localparam int SECTOR_WORDS = 256;
   localparam int NUM_ATTR = 30;
   localparam int ENTRY_BYTES = 12;
   localparam logic [8:0] ENTRY_BASE = 9'h002;
   localparam logic [8:0] ENTRY_END = 9'h169;
   localparam logic [8:0] CAP_LO = 9'h170;
   localparam logic [8:0] CAP_HI = 9'h171;
   localparam logic [8:0] CHECKSUM_POS = 9'h1FF;
   // relative offsets inside one entry
   localparam logic [3:0] REL_ID = 4'h0;
   localparam logic [3:0] REL_FLAG_LO = 4'h1;
   localparam logic [3:0] REL_FLAG_HI = 4'h2;
   localparam logic [3:0] REL_CUR = 4'h3;
   localparam logic [3:0] REL_WORST = 4'h4;
   localparam logic [3:0] REL_RAW0 = 4'h5;
   localparam logic [3:0] REL_RAW5 = 4'hA;
   localparam logic [3:0] REL_THRESH = 4'h1;
   // subcommand codes in the feature select register
   localparam logic [7:0] SUB_READ_VALUES = 8'hD0;
   localparam logic [7:0] SUB_READ_THRESH = 8'hD1;
   localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
   localparam logic [7:0] SUB_SAVE = 8'hD3;
   localparam logic [7:0] SUB_ENABLE = 8'hD8;
   localparam logic [7:0] SUB_DISABLE = 8'hD9;
   localparam logic [7:0] SUB_STATUS = 8'hDA;
   localparam logic [7:0] RES_OK_LO = 8'h4F;
   localparam logic [7:0] RES_OK_HI = 8'hC2;
   localparam logic [7:0] RES_FAIL_LO = 8'hF4;
   localparam logic [7:0] RES_FAIL_HI = 8'h2C;
   localparam logic [7:0] VALUE_MIN = 8'h01;
   localparam logic [7:0] VALUE_MAX = 8'h64;
   localparam logic [7:0] ID_CRC = 8'hC7;
   localparam logic [7:0] ID_WRITE_ERR = 8'hC8;
   localparam logic [15:0] FORMAT_VERSION = 16'h0001;
   // autosave interval
   localparam int AUTOSAVE_MIN = 15;
   localparam int CLK_HZ = 25000000;
   localparam longint AUTOSAVE_CYCLES = longint'(AUTOSAVE_MIN) * 60 * CLK_HZ;
   // AXI register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_CMD = 8'h10;
   localparam logic [7:0] REG_RESULT = 8'h14;
   localparam logic [7:0] REG_ATTR_SEL = 8'h18;
   localparam logic [7:0] REG_ATTR_ID = 8'h1C;
   localparam logic [7:0] REG_ATTR_THR = 8'h20;
   localparam logic [7:0] REG_ATTR_RAW_LO = 8'h24;
   localparam logic [7:0] REG_ATTR_RAW_HI = 8'h28;
   localparam logic [7:0] REG_ATTR_CUR = 8'h2C;
   localparam logic [7:0] REG_CAP = 8'h30;
   localparam logic [7:0] REG_WORST = 8'h34;
   // interrupt bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_SAVE = 2;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [7:0] id;
      logic inWarranty;
      logic [7:0] current;
      logic [7:0] worst;
      logic [47:0] raw;
      logic [7:0] threshold;
   } fps_attr_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
      logic last;
   } fps_word_t;
endpackage

// ==== fps_sector_builder.sv ====
// failure-prediction sector builder with AXI4-Lite registers
// Summary of operation
// R1 - value sector, 512 bytes, on subcommand D0h
// R2 - threshold sector, 512 bytes, on subcommand D1h
// R3 - same format version at bytes 00-01
// R4 - value sector holds 30 twelve-byte entries
// R5 - threshold entries: id, threshold, reserved
// R6 - value sector tail: reserved, capability, vendor, checksum
// R7 - threshold sector tail: reserved, vendor, checksum
// R8 - attribute ids follow the defined encoding
// R9 - status flag bit 0 marks warranty range
// R10 - current value clamped to 01h..64h
// R11 - normal only while every value exceeds threshold
// R12 - worst value tracks value nearest failure
// R13 - six raw bytes hold unnormalized data
// R14 - capability bits 0 and 1, rest reserved
// R15 - last byte makes sector sum zero
// R16 - return status loads 4Fh/C2h or F4h/2Ch
// R17 - autosave every 15 minutes when enabled
// R18 - reserved bytes and bits read zero
// R19 - ascending order, little-endian 16-bit words
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fps_sector_builder #(
   parameter int NUM_ATTR = fps_pkg::NUM_ATTR,
   parameter longint AUTOSAVE_CYCLES = fps_pkg::AUTOSAVE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   // subcommand from the task-file decoder
   input wire logic cmdValid,
   input wire logic [7:0] feature_select_register,
   input wire logic [7:0] sectorCount,
   // sector words toward the host
   output fps_pkg::fps_word_t dataOut,
   input wire logic dataReady,
   output logic [7:0] result_low_register,
   output logic [7:0] result_high_register,
   output logic busy,
   output logic saveRequest,
   input wire logic powerSaveEntry,
   output logic irq,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_DONE} fps_state_t;

   logic rstMeta, rstSync;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // attribute store
   fps_pkg::fps_attr_t attr [NUM_ATTR];
   logic [1:0] cap, next_cap;
   logic predictEn, next_predictEn, autoSaveEn, next_autoSaveEn;
   logic [4:0] attrSel, next_attrSel;
   logic [2:0] irqStat, next_irqStat, irqMask, next_irqMask;
   logic [7:0] resLo, resHi, next_resLo, next_resHi;
   logic [63:0] saveCnt, next_saveCnt;
   logic allNormal;

   // streamer state
   fps_state_t state, next_state;
   logic isThresh, next_isThresh;
   logic [7:0] wordIdx, next_wordIdx;
   logic [7:0] sum, next_sum;
   fps_pkg::fps_word_t next_dataOut;

   // AXI slave state
   logic awHeld, next_awHeld, wHeld, next_wHeld;
   logic [7:0] awAddr, next_awAddr;
   logic [31:0] wData, next_wData;
   logic [3:0] wStrb, next_wStrb;
   logic bValid, next_bValid, rValid, next_rValid;
   logic [1:0] bResp, next_bResp, rResp, next_rResp;
   logic [31:0] rData, next_rData;
   logic doWrite;

   always_comb begin
      allNormal = 1'b1;
      for (int i = 0; i < NUM_ATTR; i++) begin
         if (attr[i].id != 8'h00 && attr[i].current <= attr[i].threshold) begin
            allNormal = 1'b0; // R11
         end
      end
   end

   // byte of the sector at position pos, zero where reserved or vendor
   function automatic logic [7:0] sectorByte(input logic [8:0] pos, input logic thr);
      logic [8:0] off;
      logic [4:0] ent;
      logic [3:0] rel;
      logic [7:0] b;
      b = 8'h00; // R18
      off = 9'h000;
      ent = 5'd0;
      rel = 4'h0;
      if (pos == 9'h000) begin
         b = fps_pkg::FORMAT_VERSION[7:0]; // R3
      end else if (pos == 9'h001) begin
         b = fps_pkg::FORMAT_VERSION[15:8]; // R3
      end else if (pos >= fps_pkg::ENTRY_BASE && pos <= fps_pkg::ENTRY_END) begin
         off = pos - fps_pkg::ENTRY_BASE;
         ent = 5'(off / 9'(fps_pkg::ENTRY_BYTES));
         rel = 4'(off % 9'(fps_pkg::ENTRY_BYTES));
         if (32'(ent) < NUM_ATTR) begin
            if (rel == fps_pkg::REL_ID) begin
               b = attr[ent].id; // R4 R5
            end else if (thr) begin
               if (rel == fps_pkg::REL_THRESH) begin
                  b = attr[ent].threshold; // R5
               end
            end else if (rel == fps_pkg::REL_FLAG_LO) begin
               b = {7'h00, attr[ent].inWarranty}; // R9
            end else if (rel == fps_pkg::REL_CUR) begin
               b = attr[ent].current; // R4
            end else if (rel == fps_pkg::REL_WORST) begin
               b = attr[ent].worst; // R12
            end else if (rel >= fps_pkg::REL_RAW0 && rel <= fps_pkg::REL_RAW5) begin
               b = attr[ent].raw[8*(rel-fps_pkg::REL_RAW0) +: 8]; // R13
            end
         end
      end else if (!thr && pos == fps_pkg::CAP_LO) begin
         b = {6'h00, cap}; // R6 R14
      end
      return b; // R7
   endfunction

   // sector streamer: one 16-bit word per accepted handshake
   always_comb begin
      logic [7:0] lo, hi;
      logic [8:0] p;
      next_state = state;
      next_isThresh = isThresh;
      next_wordIdx = wordIdx;
      next_sum = sum;
      next_dataOut = dataOut;
      p = {wordIdx, 1'b0};
      lo = sectorByte(p, isThresh);
      hi = sectorByte(p + 9'h001, isThresh);
      if (p + 9'h001 == fps_pkg::CHECKSUM_POS) begin
         hi = 8'(-(sum + lo)); // R15
      end
      case (state)
         ST_IDLE: begin
            if (cmdValid && (feature_select_register == fps_pkg::SUB_READ_VALUES
                  || feature_select_register == fps_pkg::SUB_READ_THRESH)) begin
               next_state = ST_STREAM; // R1 R2
               next_isThresh = (feature_select_register == fps_pkg::SUB_READ_THRESH);
               next_wordIdx = 8'h00;
               next_sum = 8'h00;
               next_dataOut.valid = 1'b0;
            end
         end
         ST_STREAM: begin
            if (!dataOut.valid || dataReady) begin
               next_dataOut.valid = 1'b1;
               next_dataOut.data = {hi, lo}; // R19
               next_dataOut.last = (wordIdx == 8'(fps_pkg::SECTOR_WORDS - 1));
               next_sum = sum + lo + hi; // R15
               next_wordIdx = wordIdx + 8'h01;
               if (wordIdx == 8'(fps_pkg::SECTOR_WORDS - 1)) begin
                  next_state = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            if (dataReady) begin
               next_dataOut.valid = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         state <= ST_IDLE;
         isThresh <= 1'b0;
         wordIdx <= 8'h00;
         sum <= 8'h00;
         dataOut <= '0;
      end else begin
         state <= next_state;
         isThresh <= next_isThresh;
         wordIdx <= next_wordIdx;
         sum <= next_sum;
         dataOut <= next_dataOut;
      end
   end

   // subcommands, autosave timer, registers, interrupts
   logic [7:0] wa;
   logic saveNow, statusCmd;
   always_comb begin
      next_cap = cap;
      next_predictEn = predictEn;
      next_autoSaveEn = autoSaveEn;
      next_attrSel = attrSel;
      next_irqMask = irqMask;
      next_irqStat = irqStat;
      next_resLo = resLo;
      next_resHi = resHi;
      next_saveCnt = saveCnt;
      saveNow = 1'b0;
      statusCmd = cmdValid && state == ST_IDLE
         && feature_select_register == fps_pkg::SUB_STATUS;
      wa = awAddr;
      if (cmdValid && state == ST_IDLE) begin
         case (feature_select_register)
            fps_pkg::SUB_AUTOSAVE: next_autoSaveEn = (sectorCount != 8'h00);
            fps_pkg::SUB_SAVE: saveNow = 1'b1;
            fps_pkg::SUB_ENABLE: next_predictEn = 1'b1;
            fps_pkg::SUB_DISABLE: next_predictEn = 1'b0;
            default: ;
         endcase
      end
      if (statusCmd) begin
         saveNow = 1'b1;
         next_resLo = allNormal ? fps_pkg::RES_OK_LO : fps_pkg::RES_FAIL_LO; // R16
         next_resHi = allNormal ? fps_pkg::RES_OK_HI : fps_pkg::RES_FAIL_HI; // R16
      end
      if (powerSaveEntry && cap[0]) begin
         saveNow = 1'b1; // R14
      end
      if (autoSaveEn && predictEn) begin
         if (saveCnt >= 64'(AUTOSAVE_CYCLES - 1)) begin
            saveNow = 1'b1; // R17
         end else begin
            next_saveCnt = saveCnt + 64'h1;
         end
      end
      if (saveNow) begin
         next_saveCnt = 64'h0; // R17
      end
      if (doWrite) begin
         case (wa)
            fps_pkg::REG_CTRL: begin
               next_predictEn = wData[0];
               next_autoSaveEn = wData[1];
            end
            fps_pkg::REG_IRQ_STAT: next_irqStat = irqStat & ~wData[2:0];
            fps_pkg::REG_IRQ_MASK: next_irqMask = wData[2:0];
            fps_pkg::REG_ATTR_SEL: next_attrSel = wData[4:0];
            fps_pkg::REG_CAP: next_cap = wData[1:0]; // R14
            default: ;
         endcase
      end
      // set wins over the write-one clear
      if (state == ST_DONE && dataReady) next_irqStat[fps_pkg::IRQ_DONE] = 1'b1;
      if (statusCmd && !allNormal) next_irqStat[fps_pkg::IRQ_FAIL] = 1'b1;
      if (saveNow) next_irqStat[fps_pkg::IRQ_SAVE] = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         cap <= 2'b11;
         predictEn <= 1'b1;
         autoSaveEn <= 1'b0;
         attrSel <= 5'd0;
         irqMask <= 3'h0;
         irqStat <= 3'h0;
         resLo <= fps_pkg::RES_OK_LO;
         resHi <= fps_pkg::RES_OK_HI;
         saveCnt <= 64'h0;
         saveRequest <= 1'b0;
      end else begin
         cap <= next_cap;
         predictEn <= next_predictEn;
         autoSaveEn <= next_autoSaveEn;
         attrSel <= next_attrSel;
         irqMask <= next_irqMask;
         irqStat <= next_irqStat;
         resLo <= next_resLo;
         resHi <= next_resHi;
         saveCnt <= next_saveCnt;
         saveRequest <= saveNow;
      end
   end

   // attribute table, written by firmware
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         for (int i = 0; i < NUM_ATTR; i++) begin
            attr[i] <= '0;
         end
      end else if (doWrite && 32'(attrSel) < NUM_ATTR) begin
         case (wa)
            fps_pkg::REG_ATTR_ID: begin
               attr[attrSel].id <= wData[7:0]; // R8
               attr[attrSel].inWarranty <= wData[8]; // R9
               attr[attrSel].worst <= fps_pkg::VALUE_MAX;
               attr[attrSel].current <= fps_pkg::VALUE_MAX;
            end
            fps_pkg::REG_ATTR_THR: attr[attrSel].threshold <= wData[7:0];
            fps_pkg::REG_ATTR_RAW_LO: attr[attrSel].raw[31:0] <= wData;
            fps_pkg::REG_ATTR_RAW_HI: attr[attrSel].raw[47:32] <= wData[15:0];
            fps_pkg::REG_ATTR_CUR: begin
               logic [7:0] v;
               v = wData[7:0];
               if (v < fps_pkg::VALUE_MIN) v = fps_pkg::VALUE_MIN; // R10
               if (v > fps_pkg::VALUE_MAX) v = fps_pkg::VALUE_MAX; // R10
               attr[attrSel].current <= v;
               if (v < attr[attrSel].worst) attr[attrSel].worst <= v; // R12
            end
            default: ;
         endcase
      end
   end

   // AXI4-Lite: address and data taken in either order, one response per write
   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awAddr = awAddr;
      next_wData = wData;
      next_wStrb = wStrb;
      next_bValid = bValid;
      next_bResp = bResp;
      next_rValid = rValid;
      next_rResp = rResp;
      next_rData = rData;
      doWrite = awHeld && wHeld && !bValid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wData = s_axi_wdata;
         next_wStrb = s_axi_wstrb;
      end
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bValid = 1'b1;
         next_bResp = (awAddr > fps_pkg::REG_WORST || awAddr[1:0] != 2'b00)
            ? fps_pkg::RESP_SLVERR : fps_pkg::RESP_OKAY;
      end
      if (bValid && s_axi_bready) next_bValid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rValid = 1'b1;
         next_rResp = fps_pkg::RESP_OKAY;
         next_rData = 32'h0;
         case (s_axi_araddr)
            fps_pkg::REG_CTRL: next_rData = {30'h0, autoSaveEn, predictEn};
            fps_pkg::REG_STATUS: next_rData = {28'h0, busy, busy, !allNormal, allNormal};
            fps_pkg::REG_IRQ_STAT: next_rData = {29'h0, irqStat};
            fps_pkg::REG_IRQ_MASK: next_rData = {29'h0, irqMask};
            fps_pkg::REG_RESULT: next_rData = {16'h0, resHi, resLo};
            fps_pkg::REG_ATTR_SEL: next_rData = {27'h0, attrSel};
            fps_pkg::REG_CAP: next_rData = {30'h0, cap};
            fps_pkg::REG_WORST: next_rData = (32'(attrSel) < NUM_ATTR)
               ? {16'h0, attr[attrSel].current, attr[attrSel].worst} : 32'h0;
            fps_pkg::REG_CMD, fps_pkg::REG_ATTR_ID, fps_pkg::REG_ATTR_THR,
            fps_pkg::REG_ATTR_RAW_LO, fps_pkg::REG_ATTR_RAW_HI,
            fps_pkg::REG_ATTR_CUR: next_rData = 32'h0;
            default: next_rResp = fps_pkg::RESP_SLVERR;
         endcase
      end
      if (rValid && s_axi_rready) next_rValid = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0;
         wStrb <= 4'h0;
         bValid <= 1'b0;
         bResp <= 2'b00;
         rValid <= 1'b0;
         rResp <= 2'b00;
         rData <= 32'h0;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wData <= next_wData;
         wStrb <= next_wStrb;
         bValid <= next_bValid;
         bResp <= next_bResp;
         rValid <= next_rValid;
         rResp <= next_rResp;
         rData <= next_rData;
      end
   end

   assign s_axi_awready = !awHeld && !bValid;
   assign s_axi_wready = !wHeld && !bValid;
   assign s_axi_bvalid = bValid;
   assign s_axi_bresp = bResp;
   assign s_axi_arready = !rValid;
   assign s_axi_rvalid = rValid;
   assign s_axi_rresp = rResp;
   assign s_axi_rdata = rData;
   assign result_low_register = resLo;
   assign result_high_register = resHi;
   assign busy = state != ST_IDLE;
   assign irq = |(irqStat & irqMask);
endmodule
`default_nettype wire

// ==== fps_sector_builder_chk.sv ====
// concurrent checks on the sector stream and status results
`timescale 1ns/100ps
`default_nettype none
module fps_sector_builder_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmdValid,
   input wire logic [7:0] feature_select_register,
   input wire fps_pkg::fps_word_t dataOut,
   input wire logic dataReady,
   input wire logic [7:0] result_low_register,
   input wire logic [7:0] result_high_register,
   input wire logic busy,
   input wire logic saveRequest
);
   logic hs;
   logic [7:0] cnt, sum, next_cnt, next_sum;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   assign hs = dataOut.valid && dataReady;
   always_comb begin
      next_cnt = cnt;
      next_sum = sum;
      if (hs) begin
         next_cnt = dataOut.last ? 8'h00 : cnt + 8'h01;
         next_sum = dataOut.last ? 8'h00 : 8'(sum + dataOut.data[7:0] + dataOut.data[15:8]);
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 8'h00;
         sum <= 8'h00;
      end else begin
         cnt <= next_cnt;
         sum <= next_sum;
      end
   end
   sequence startSeq;
      cmdValid && !busy && feature_select_register inside {8'hD0, 8'hD1};
   endsequence
   sequence firstWord;
      busy ##1 dataOut.valid;
   endsequence
   sector_start_a: assert property (startSeq |=> firstWord)
      else $error("late sector start");
   word_hold_a: assert property (dataOut.valid && !dataReady |=>
      dataOut.valid && $stable(dataOut.data)) else $error("word changed before taken");
   last_count_a: assert property (hs && dataOut.last |-> cnt == 8'hFF)
      else $error("last flag not on word 255");
   sum_zero_a: assert property (hs && dataOut.last |->
      8'(sum + dataOut.data[7:0] + dataOut.data[15:8]) == 8'h00) else $error("bad checksum");
   version_word_a: assert property (hs && cnt == 8'h00 |->
      dataOut.data == fps_pkg::FORMAT_VERSION) else $error("bad version word");
   sector_end_a: assert property (hs && dataOut.last |=> !busy && !dataOut.valid)
      else $error("stream ran past last word");
   result_pair_a: assert property ({result_high_register, result_low_register}
      inside {16'hC24F, 16'h2CF4}) else $error("illegal result pair");
   status_save_a: assert property (cmdValid && !busy && feature_select_register == 8'hDA
      |=> saveRequest ##1 !saveRequest) else $error("status did not save once");
endmodule
bind fps_sector_builder fps_sector_builder_chk chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .cmdValid(cmdValid), .feature_select_register(feature_select_register),
   .dataOut(dataOut), .dataReady(dataReady), .result_low_register(result_low_register),
   .result_high_register(result_high_register), .busy(busy), .saveRequest(saveRequest));
`default_nettype wire

// ==== fps_host_model.sv ====
// host model: drains sector words into a byte array
`timescale 1ns/100ps
`default_nettype none
module fps_host_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire fps_pkg::fps_word_t dataOut,
   input wire logic slow,
   output logic dataReady
);
   logic [7:0] sec [0:511];
   logic [31:0] got;
   logic [7:0] idx;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dataReady <= 1'b0;
         idx <= 8'h00;
         got <= 32'h0;
      end else begin
         // a slow host drops ready every other cycle so the hold is exercised
         dataReady <= slow ? !dataReady : 1'b1;
         if (dataOut.valid && dataReady) begin
            sec[{idx, 1'b0}] <= dataOut.data[7:0];
            sec[{idx, 1'b1}] <= dataOut.data[15:8];
            idx <= dataOut.last ? 8'h00 : idx + 8'h01;
            if (dataOut.last) got <= {24'h0, idx} + 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== fps_sector_builder_test.sv ====
// self-checking bench for the failure-prediction sector builder
`timescale 1ns/100ps
`default_nettype none
module fps_sector_builder_test;
   import fps_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, slow = 1'b0;
   logic [7:0] fsr = 8'h00, sc = 8'h00, awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic dataReady, busy, saveRequest, irq, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [7:0] resLo, resHi;
   fps_word_t dataOut;
   int n_errors = 0, n_checks = 0;
   localparam int SAVE_N = 50;
   fps_sector_builder #(.AUTOSAVE_CYCLES(SAVE_N)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
      .cmdValid(cmdValid), .feature_select_register(fsr), .sectorCount(sc),
      .dataOut(dataOut), .dataReady(dataReady), .result_low_register(resLo),
      .result_high_register(resHi), .busy(busy), .saveRequest(saveRequest),
      .powerSaveEntry(1'b0), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   fps_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .dataOut(dataOut),
      .slow(slow), .dataReady(dataReady));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic stop_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
      logic pa, pw, ta, tw, tr;
      int t;
      pa = 1'b1;
      pw = w;
      tr = 1'b0;
      t = 0;
      @(posedge ref_clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w;
      rready <= !w;
      while (!tr && t < 100) begin
         @(negedge ref_clk);
         ta = pa && (w ? awready : arready);
         tw = pw && wready;
         tr = w ? bvalid : rvalid;
         q = rdata;
         r = w ? bresp : rresp;
         t++;
         @(posedge ref_clk);
         pa = pa && !ta;
         pw = pw && !tw;
         awvalid <= w && pa;
         arvalid <= !w && pa;
         wvalid <= pw;
         bready <= w && !tr;
         rready <= !w && !tr;
      end
      chk(tr, 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      ax(1'b1, a, d, q, r);
      chk(r, RESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      ax(1'b0, a, 32'h0, q, r);
      chk(q, e);
      chk(r, er);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] n);
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      fsr <= c;
      sc <= n;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
   endtask
   task automatic zeros(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) chk(host.sec[i], 8'h00);
   endtask
   task automatic sector(input logic [7:0] c);
      int t;
      logic [7:0] s;
      cmd(c, 8'h00);
      t = 0;
      s = 8'h00;
      do begin
         @(negedge ref_clk);
         t++;
      end while (busy !== 1'b0 && t < 3000);
      for (int i = 0; i < 512; i++) s += host.sec[i];
      chk(host.got, 32'h100);
      chk(s, 8'h00);
      chk({host.sec[1], host.sec[0]}, FORMAT_VERSION);
   endtask
   task automatic t_setup;
      chk({resHi, resLo}, 16'hC24F);
      rd(REG_CAP, 32'h3, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(REG_ATTR_SEL, 32'h0);
      wr(REG_ATTR_ID, 32'h1C7);
      wr(REG_ATTR_THR, 32'h0A);
      wr(REG_ATTR_RAW_LO, 32'h44332211);
      wr(REG_ATTR_RAW_HI, 32'h6655);
      wr(REG_ATTR_CUR, 32'h28);
      wr(REG_ATTR_CUR, 32'h3C);
      rd(REG_WORST, 32'h3C28, RESP_OKAY);
   endtask
   task automatic t_values;
      logic [7:0] e [12] = '{8'hC7, 8'h01, 8'h00, 8'h3C, 8'h28, 8'h11,
         8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00};
      sector(SUB_READ_VALUES);
      for (int i = 0; i < 12; i++) chk(host.sec[2 + i], e[i]);
      chk({host.sec[9'h171], host.sec[9'h170]}, 16'h0003);
      zeros(9'h16A, 9'h16F);
      zeros(9'h172, 9'h181);
   endtask
   task automatic t_thresh;
      slow <= 1'b1;
      sector(SUB_READ_THRESH);
      chk({host.sec[3], host.sec[2]}, 16'h0AC7);
      zeros(4, 13);
      zeros(9'h16A, 9'h17B);
      slow <= 1'b0;
   endtask
   task automatic t_status;
      cmd(SUB_STATUS, 8'h00);
      @(negedge ref_clk);
      chk({resHi, resLo}, 16'hC24F);
      wr(REG_IRQ_MASK, 32'h2);
      chk(irq, 1'b0);
      wr(REG_ATTR_CUR, 32'h0A);
      cmd(SUB_STATUS, 8'h00);
      @(negedge ref_clk);
      chk({resHi, resLo}, 16'h2CF4);
      chk(irq, 1'b1);
      wr(REG_IRQ_STAT, 32'h2);
      @(negedge ref_clk);
      chk(irq, 1'b0);
      wr(REG_ATTR_CUR, 32'h0);
      rd(REG_WORST, 32'h0101, RESP_OKAY);
   endtask
   task automatic t_autosave;
      int t, n;
      cmd(SUB_AUTOSAVE, 8'h01);
      t = 0;
      while (saveRequest !== 1'b1 && t < 200) begin
         @(negedge ref_clk);
         t++;
      end
      t = 0;
      do begin
         @(negedge ref_clk);
         t++;
      end while (saveRequest !== 1'b1 && t < 200);
      chk(t, SAVE_N);
      cmd(SUB_DISABLE, 8'h00);
      n = 0;
      repeat (120) begin
         @(negedge ref_clk);
         if (saveRequest === 1'b1) n++;
      end
      chk(n, 0);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_setup();
      t_values();
      t_thresh();
      t_status();
      t_autosave();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
